// *** design/cmg_pkg.sv ***
// Purpose: Shared constants, encodings and helpers for the colour matrix and gamma stage
// Assumes: 16-bit register data, one register per address, 10-bit pixel components
// Notes: Reset values give an identity matrix, all gamma bypassed and unity contrast
package cmg_pkg;

   localparam int CMG_AW = 5;
   localparam int CMG_DW = 16;
   localparam int CMG_PIX_W = 10;
   localparam int CMG_Y_W = 8;
   localparam int CMG_COEF_W = 12;
   localparam int CMG_OFS_W = 14;
   localparam int CMG_YCC_W = 10;
   localparam int CMG_LUT_AW = 9;
   localparam int CMG_LUT_DEPTH = 512;
   localparam int CMG_COEF_FRAC = 8;
   localparam int CMG_CONTRAST_FRAC = 4;

   // Register addresses
   localparam logic [4:0] CMG_OFS_COEF_R_FROM_R = 5'h00;
   localparam logic [4:0] CMG_OFS_COEF_G_FROM_R = 5'h01;
   localparam logic [4:0] CMG_OFS_COEF_B_FROM_R = 5'h02;
   localparam logic [4:0] CMG_OFS_COEF_R_FROM_G = 5'h03;
   localparam logic [4:0] CMG_OFS_COEF_G_FROM_G = 5'h04;
   localparam logic [4:0] CMG_OFS_COEF_B_FROM_G = 5'h05;
   localparam logic [4:0] CMG_OFS_COEF_R_FROM_B = 5'h06;
   localparam logic [4:0] CMG_OFS_COEF_G_FROM_B = 5'h07;
   localparam logic [4:0] CMG_OFS_COEF_B_FROM_B = 5'h08;
   localparam logic [4:0] CMG_OFS_RED_OUTPUT_OFFSET = 5'h09;
   localparam logic [4:0] CMG_OFS_GAMMA_CONFIG = 5'h0C;
   localparam logic [4:0] CMG_OFS_LUMA_BRIGHTNESS_CONTRAST = 5'h0D;
   localparam logic [4:0] CMG_OFS_YUV_COEF_LUMA_FROM_RED = 5'h0E;
   localparam logic [4:0] CMG_OFS_YUV_COEF_BLUE_DIFF_FROM_RED = 5'h11;
   localparam logic [4:0] CMG_OFS_GAMMA_TABLE_ADDR = 5'h12;
   localparam logic [4:0] CMG_OFS_GAMMA_TABLE_DATA = 5'h13;
   localparam logic [4:0] CMG_OFS_STATUS = 5'h14;

   // Gamma configuration fields
   localparam int CMG_GMM_SIZE_LSB = 5;
   localparam int CMG_GMM_SIZE_MSB = 6;
   localparam int CMG_GMM_SRC_BIT = 4;
   localparam int CMG_GMM_SKIP_B_BIT = 2;
   localparam int CMG_GMM_SKIP_G_BIT = 1;
   localparam int CMG_GMM_SKIP_R_BIT = 0;
   localparam logic [15:0] CMG_GAMMA_CONFIG_MASK = 16'h0077;

   // Luminance adjustment fields
   localparam int CMG_BRIGHT_LSB = 8;
   localparam int CMG_CONTRAST_LSB = 0;

   // Reset values
   localparam logic [11:0] CMG_RST_COEF_DIAG = 12'h100;
   localparam logic [11:0] CMG_RST_COEF_CROSS = 12'h000;
   localparam logic [13:0] CMG_RST_OUT_OFFSET = 14'h0000;
   localparam logic [15:0] CMG_RST_GAMMA_CONFIG = 16'h0027;
   localparam logic [15:0] CMG_RST_LUMA_ADJ = 16'h0010;
   localparam logic [9:0] CMG_RST_YUV_COEF = 10'h000;
   localparam logic [8:0] CMG_RST_LUT_ADDR = 9'h000;

   typedef enum logic [1:0] {
      CMG_LUT_128 = 2'h0,
      CMG_LUT_256 = 2'h1,
      CMG_LUT_RSVD = 2'h2,
      CMG_LUT_512 = 2'h3
   } cmg_lut_size_t;

   // Clamp a signed intermediate to the unsigned 10-bit pixel range
   function automatic logic [9:0] cmg_clip10(input logic signed [25:0] v);
      if (v < 26'sd0) begin
         return 10'h000;
      end else if (v > 26'sd1023) begin
         return 10'h3FF;
      end
      return v[9:0];
   endfunction

endpackage

// *** design/cmg_gamma_lut.sv ***
// Purpose: Per-channel gamma lookup from a writable table or a fixed curve
// Assumes: Table writes never coincide with a change of table size
// Notes: One registered stage; the table is shared by all three channels
module cmg_gamma_lut import cmg_pkg::*; (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [1:0] gamma_table_size_i,
   input wire logic gamma_source_select_i,
   input wire logic [2:0] gamma_skip_i,
   input wire logic lut_we_i,
   input wire logic [8:0] lut_addr_i,
   input wire logic [9:0] lut_wdata_i,
   output logic [9:0] lut_rdata_o,
   input wire logic in_valid_i,
   input wire logic [9:0] in_r_i,
   input wire logic [9:0] in_g_i,
   input wire logic [9:0] in_b_i,
   output logic out_valid_o,
   output logic [9:0] out_r_o,
   output logic [9:0] out_g_o,
   output logic [9:0] out_b_o
);

   logic [9:0] table_mem [CMG_LUT_DEPTH];
   logic [9:0] pix_in [3];
   logic [9:0] pix_reg [3];
   logic valid_reg;

   // Reserved size code behaves as the 256-entry table
   function automatic logic [8:0] lut_index(input logic [9:0] pix, input logic [1:0] size_code);
      case (size_code)
         CMG_LUT_128: return {2'h0, pix[9:3]};
         CMG_LUT_512: return pix[9:1];
         default: return {1'b0, pix[9:2]};
      endcase
   endfunction

   // Fixed curve is linear: an index scaled back to full pixel range
   function automatic logic [9:0] rom_entry(input logic [8:0] idx, input logic [1:0] size_code);
      case (size_code)
         CMG_LUT_128: return {idx[6:0], 3'h0};
         CMG_LUT_512: return {idx[8:0], 1'b0};
         default: return {idx[7:0], 2'h0};
      endcase
   endfunction

   always_ff @(posedge clock_i) begin
      if (lut_we_i) begin
         table_mem[lut_addr_i] <= lut_wdata_i;
      end
   end

   assign lut_rdata_o = table_mem[lut_addr_i];
   assign pix_in[0] = in_r_i;
   assign pix_in[1] = in_g_i;
   assign pix_in[2] = in_b_i;

   for (genvar c = 0; c < 3; c++) begin : g_chan
      logic [8:0] idx;
      logic [9:0] looked;
      assign idx = lut_index(pix_in[c], gamma_table_size_i);
      assign looked = gamma_source_select_i ? rom_entry(idx, gamma_table_size_i)
                                            : table_mem[idx];
      always_ff @(posedge clock_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            pix_reg[c] <= 10'h000;
         end else if (in_valid_i) begin
            pix_reg[c] <= gamma_skip_i[c] ? pix_in[c] : looked;
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         valid_reg <= 1'b0;
      end else begin
         valid_reg <= in_valid_i;
      end
   end

   assign out_valid_o = valid_reg;
   assign out_r_o = pix_reg[0];
   assign out_g_o = pix_reg[1];
   assign out_b_o = pix_reg[2];

endmodule

// *** design/cmg_luma_adj.sv ***
// Purpose: Luminance from RGB, then contrast gain and brightness offset
// Assumes: Coefficients are signed with eight fractional bits
// Notes: One registered stage; luminance is kept to eight bits before scaling
module cmg_luma_adj import cmg_pkg::*; (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [9:0] coef_y_r_i,
   input wire logic [9:0] coef_y_g_i,
   input wire logic [9:0] coef_y_b_i,
   input wire logic [7:0] brightness_offset_i,
   input wire logic [7:0] contrast_gain_i,
   input wire logic in_valid_i,
   input wire logic [9:0] in_r_i,
   input wire logic [9:0] in_g_i,
   input wire logic [9:0] in_b_i,
   output logic out_valid_o,
   output logic [7:0] out_y_o
);

   logic signed [25:0] mac;
   logic [9:0] y_full;
   logic [15:0] scaled;
   logic [12:0] lifted;
   logic [7:0] y_reg;
   logic valid_reg;

   always_comb begin
      mac = 26'($signed(coef_y_r_i) * $signed({1'b0, in_r_i}))
          + 26'($signed(coef_y_g_i) * $signed({1'b0, in_g_i}))
          + 26'($signed(coef_y_b_i) * $signed({1'b0, in_b_i}));
      y_full = cmg_clip10(mac >>> CMG_COEF_FRAC);
      scaled = y_full[9:2] * contrast_gain_i;
      lifted = 13'(scaled >> CMG_CONTRAST_FRAC) + 13'(brightness_offset_i);
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         y_reg <= 8'h00;
         valid_reg <= 1'b0;
      end else begin
         valid_reg <= in_valid_i;
         if (in_valid_i) begin
            // Saturate rather than wrap so bright scenes do not fold to black
            y_reg <= (lifted > 13'h0FF) ? 8'hFF : lifted[7:0];
         end
      end
   end

   assign out_valid_o = valid_reg;
   assign out_y_o = y_reg;

endmodule

// *** design/cmg_color_stage.sv ***
// Purpose: Register bank and datapath of the colour matrix, gamma and luma stage
// Assumes: Pixels arrive as 10-bit unsigned RGB with a valid strobe, no back-pressure
// Notes: Three-stage pipe; configuration changes take effect on the next pixel
//
// Design decisions made here: the address map and the plain strobed port.
module cmg_color_stage import cmg_pkg::*; (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [4:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire logic pix_valid_i,
   input wire logic [9:0] pix_r_i,
   input wire logic [9:0] pix_g_i,
   input wire logic [9:0] pix_b_i,
   output logic out_valid_o,
   output logic [9:0] out_r_o,
   output logic [9:0] out_g_o,
   output logic [9:0] out_b_o,
   output logic [7:0] out_y_o,
   output logic [9:0] cb_coef_from_red_o
);

   // Matrix coefficients, index = source * 3 + destination
   logic [11:0] coef_reg [9];
   logic [13:0] out_offset_reg [3];
   logic [15:0] gamma_config_reg;
   logic [15:0] luma_brightness_contrast_reg;
   logic [9:0] yuv_coef_reg [4];
   logic [8:0] lut_addr_reg;
   logic [15:0] rdata_reg;

   logic [9:0] pix_in [3];
   logic [9:0] mtx_reg [3];
   logic mtx_valid_reg;
   logic [9:0] out_rgb_reg [3];

   logic gmm_valid;
   logic [9:0] gmm_r;
   logic [9:0] gmm_g;
   logic [9:0] gmm_b;
   logic [9:0] lut_rdata;
   logic lut_we;
   logic luma_valid;
   logic [1:0] gamma_table_size;
   logic gamma_source_select;
   logic [2:0] gamma_skip;
   logic [7:0] brightness_offset;
   logic [7:0] contrast_gain;
   logic pipe_busy;

   // Address range decode used only by the read path; writes compare each address directly
   function automatic logic in_range(input logic [4:0] a, input logic [4:0] base,
                                     input int count);
      return (a >= base) && (32'(a) < 32'(base) + count);
   endfunction

   // Matrix coefficients: identity after reset
   for (genvar k = 0; k < 9; k++) begin : g_coef
      always_ff @(posedge clock_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            coef_reg[k] <= (k % 4 == 0) ? CMG_RST_COEF_DIAG : CMG_RST_COEF_CROSS;
         end else if (wr_i && addr_i == 5'(CMG_OFS_COEF_R_FROM_R + k)) begin
            coef_reg[k] <= wdata_i[CMG_COEF_W-1:0];
         end
      end
   end

   for (genvar c = 0; c < 3; c++) begin : g_ofs
      always_ff @(posedge clock_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            out_offset_reg[c] <= CMG_RST_OUT_OFFSET;
         end else if (wr_i && addr_i == 5'(CMG_OFS_RED_OUTPUT_OFFSET + c)) begin
            out_offset_reg[c] <= wdata_i[CMG_OFS_W-1:0];
         end
      end
   end

   for (genvar k = 0; k < 4; k++) begin : g_yuv
      always_ff @(posedge clock_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            yuv_coef_reg[k] <= CMG_RST_YUV_COEF;
         end else if (wr_i && addr_i == 5'(CMG_OFS_YUV_COEF_LUMA_FROM_RED + k)) begin
            yuv_coef_reg[k] <= wdata_i[CMG_YCC_W-1:0];
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gamma_config_reg <= CMG_RST_GAMMA_CONFIG;
      end else if (wr_i && addr_i == CMG_OFS_GAMMA_CONFIG) begin
         // Reserved bits are not stored so they always read back as zero
         gamma_config_reg <= wdata_i & CMG_GAMMA_CONFIG_MASK;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         luma_brightness_contrast_reg <= CMG_RST_LUMA_ADJ;
      end else if (wr_i && addr_i == CMG_OFS_LUMA_BRIGHTNESS_CONTRAST) begin
         luma_brightness_contrast_reg <= wdata_i;
      end
   end

   // Table pointer steps after each data write so a whole curve loads in a burst
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lut_addr_reg <= CMG_RST_LUT_ADDR;
      end else if (wr_i && addr_i == CMG_OFS_GAMMA_TABLE_ADDR) begin
         lut_addr_reg <= wdata_i[CMG_LUT_AW-1:0];
      end else if (lut_we) begin
         lut_addr_reg <= lut_addr_reg + 9'h001;
      end
   end

   assign lut_we = wr_i && addr_i == CMG_OFS_GAMMA_TABLE_DATA;

   // Configuration fields
   assign gamma_table_size = gamma_config_reg[CMG_GMM_SIZE_MSB:CMG_GMM_SIZE_LSB];
   assign gamma_source_select = gamma_config_reg[CMG_GMM_SRC_BIT];
   assign gamma_skip[2] = gamma_config_reg[CMG_GMM_SKIP_B_BIT];
   assign gamma_skip[1] = gamma_config_reg[CMG_GMM_SKIP_G_BIT];
   assign gamma_skip[0] = gamma_config_reg[CMG_GMM_SKIP_R_BIT];
   assign brightness_offset = luma_brightness_contrast_reg[CMG_BRIGHT_LSB +: 8];
   assign contrast_gain = luma_brightness_contrast_reg[CMG_CONTRAST_LSB +: 8];

   // Blending matrix stage
   assign pix_in[0] = pix_r_i;
   assign pix_in[1] = pix_g_i;
   assign pix_in[2] = pix_b_i;

   for (genvar c = 0; c < 3; c++) begin : g_mtx
      logic signed [25:0] mac;
      logic signed [25:0] biased;
      always_comb begin
         mac = 26'($signed(coef_reg[c]) * $signed({1'b0, pix_in[0]}))
             + 26'($signed(coef_reg[3 + c]) * $signed({1'b0, pix_in[1]}))
             + 26'($signed(coef_reg[6 + c]) * $signed({1'b0, pix_in[2]}));
         biased = (mac >>> CMG_COEF_FRAC) + 26'($signed(out_offset_reg[c]));
      end
      always_ff @(posedge clock_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            mtx_reg[c] <= 10'h000;
         end else if (pix_valid_i) begin
            mtx_reg[c] <= cmg_clip10(biased);
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mtx_valid_reg <= 1'b0;
      end else begin
         mtx_valid_reg <= pix_valid_i;
      end
   end

   cmg_gamma_lut u_gamma (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .gamma_table_size_i(gamma_table_size),
      .gamma_source_select_i(gamma_source_select),
      .gamma_skip_i(gamma_skip),
      .lut_we_i(lut_we),
      .lut_addr_i(lut_addr_reg),
      .lut_wdata_i(wdata_i[9:0]),
      .lut_rdata_o(lut_rdata),
      .in_valid_i(mtx_valid_reg),
      .in_r_i(mtx_reg[0]),
      .in_g_i(mtx_reg[1]),
      .in_b_i(mtx_reg[2]),
      .out_valid_o(gmm_valid),
      .out_r_o(gmm_r),
      .out_g_o(gmm_g),
      .out_b_o(gmm_b)
   );

   cmg_luma_adj u_luma (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .coef_y_r_i(yuv_coef_reg[0]),
      .coef_y_g_i(yuv_coef_reg[1]),
      .coef_y_b_i(yuv_coef_reg[2]),
      .brightness_offset_i(brightness_offset),
      .contrast_gain_i(contrast_gain),
      .in_valid_i(gmm_valid),
      .in_r_i(gmm_r),
      .in_g_i(gmm_g),
      .in_b_i(gmm_b),
      .out_valid_o(luma_valid),
      .out_y_o(out_y_o)
   );

   // RGB is delayed one stage to stay aligned with luminance
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_rgb_reg[0] <= 10'h000;
         out_rgb_reg[1] <= 10'h000;
         out_rgb_reg[2] <= 10'h000;
      end else if (gmm_valid) begin
         out_rgb_reg[0] <= gmm_r;
         out_rgb_reg[1] <= gmm_g;
         out_rgb_reg[2] <= gmm_b;
      end
   end

   assign pipe_busy = pix_valid_i | mtx_valid_reg | gmm_valid | luma_valid;

   // Read data stands only in the cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_reg <= 16'h0000;
      end else if (!rd_i) begin
         rdata_reg <= 16'h0000;
      end else if (in_range(addr_i, CMG_OFS_COEF_R_FROM_R, 9)) begin
         rdata_reg <= {4'h0, coef_reg[addr_i[3:0]]};
      end else if (in_range(addr_i, CMG_OFS_RED_OUTPUT_OFFSET, 3)) begin
         rdata_reg <= {2'h0, out_offset_reg[2'(addr_i - CMG_OFS_RED_OUTPUT_OFFSET)]};
      end else if (in_range(addr_i, CMG_OFS_YUV_COEF_LUMA_FROM_RED, 4)) begin
         rdata_reg <= {6'h00, yuv_coef_reg[2'(addr_i - CMG_OFS_YUV_COEF_LUMA_FROM_RED)]};
      end else begin
         unique case (addr_i)
            CMG_OFS_GAMMA_CONFIG: rdata_reg <= gamma_config_reg;
            CMG_OFS_LUMA_BRIGHTNESS_CONTRAST: rdata_reg <= luma_brightness_contrast_reg;
            CMG_OFS_GAMMA_TABLE_ADDR: rdata_reg <= {7'h00, lut_addr_reg};
            CMG_OFS_GAMMA_TABLE_DATA: rdata_reg <= {6'h00, lut_rdata};
            CMG_OFS_STATUS: rdata_reg <= {13'h0000, gamma_source_select,
                                          gamma_table_size == CMG_LUT_RSVD, pipe_busy};
            default: rdata_reg <= 16'h0000;
         endcase
      end
   end

   assign rdata_o = rdata_reg;
   assign out_valid_o = luma_valid;
   assign out_r_o = out_rgb_reg[0];
   assign out_g_o = out_rgb_reg[1];
   assign out_b_o = out_rgb_reg[2];
   assign cb_coef_from_red_o = yuv_coef_reg[3];

endmodule

// *** dv/cmg_color_checker.sv ***
// Purpose: Port-level checks of the colour stage register bus and pixel pipe
// Assumes: Bus master leaves one idle cycle between strobes
// Notes: Bound to every instance of the colour stage
module cmg_color_checker import cmg_pkg::*; (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [4:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [15:0] rdata_o,
   input wire logic pix_valid_i,
   input wire logic [9:0] pix_r_i,
   input wire logic [9:0] pix_g_i,
   input wire logic [9:0] pix_b_i,
   input wire logic out_valid_o,
   input wire logic [9:0] out_r_o,
   input wire logic [9:0] out_g_o,
   input wire logic [9:0] out_b_o,
   input wire logic [7:0] out_y_o,
   input wire logic [9:0] cb_coef_from_red_o
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);
   // Write, idle, read of one address returns only the stored field
   property p_back(logic [4:0] a, logic [15:0] mask);
      wr_i && addr_i == a ##2 rd_i && addr_i == a |=> rdata_o == ($past(wdata_i, 3) & mask);
   endproperty
   a_gamma_cfg_back: assert property (p_back(CMG_OFS_GAMMA_CONFIG, 16'h0077))
      else $error("gamma config readback wrong");
   a_luma_adj_back: assert property (p_back(CMG_OFS_LUMA_BRIGHTNESS_CONTRAST, 16'hFFFF))
      else $error("luma adjust readback wrong");
   a_coef_b_back: assert property (p_back(CMG_OFS_COEF_R_FROM_B, 16'h0FFF))
      else $error("blue matrix term readback wrong");
   a_offset_back: assert property (p_back(CMG_OFS_RED_OUTPUT_OFFSET, 16'h3FFF))
      else $error("output offset readback wrong");
   a_ycc_coef_back: assert property (p_back(CMG_OFS_YUV_COEF_LUMA_FROM_RED, 16'h03FF))
      else $error("luma coefficient readback wrong");
   a_coef_r_back: assert property (p_back(CMG_OFS_COEF_R_FROM_R, 16'h0FFF))
      else $error("red matrix term readback wrong");
   a_cb_level: assert property (wr_i && addr_i == CMG_OFS_YUV_COEF_BLUE_DIFF_FROM_RED |->
      ##2 cb_coef_from_red_o == $past(wdata_i[9:0], 2))
      else $error("Cb coefficient output wrong");
   a_pix_latency: assert property (pix_valid_i |-> ##3 out_valid_o)
      else $error("pixel output missing");
   a_valid_cause: assert property (out_valid_o |-> $past(pix_valid_i, 3))
      else $error("output without input pixel");
   a_out_hold: assert property (!out_valid_o |-> $stable(out_r_o) && $stable(out_g_o)
      && $stable(out_b_o))
      else $error("pixel output changed while idle");
   // Read data would smear onto the bus if it lingered past its cycle
   a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
      else $error("read data outside read cycle");
   c_pixel: cover property (out_valid_o ##1 out_valid_o);
   c_gamma_rd: cover property (rd_i && addr_i == CMG_OFS_GAMMA_CONFIG);
   c_table_rd: cover property (rd_i && addr_i == CMG_OFS_GAMMA_TABLE_DATA);
endmodule

bind cmg_color_stage cmg_color_checker u_chk (.clock_i, .rst_n_i, .addr_i, .wdata_i, .wr_i,
   .rd_i, .rdata_o, .pix_valid_i, .pix_r_i, .pix_g_i, .pix_b_i, .out_valid_o, .out_r_o,
   .out_g_o, .out_b_o, .out_y_o, .cb_coef_from_red_o);

// *** dv/cmg_color_stage_tb.sv ***
// Purpose: Self-checking bench for the colour matrix, gamma and luma stage
// Assumes: Configuration changes only while the pixel pipe is empty
// Notes: Integer model of register map and pixel math, compared at every result
module cmg_color_stage_tb import cmg_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i, rst_n_i, wr_i, rd_i, pix_valid_i, out_valid_o;
   logic [4:0] addr_i;
   logic [15:0] wdata_i, rdata_o;
   logic [9:0] pix_r_i, pix_g_i, pix_b_i, out_r_o, out_g_o, out_b_o, cb_coef_from_red_o;
   logic [7:0] out_y_o;
   int n_mismatch = 0;
   int compares = 0;
   int seed = 32'h6269;
   int m [0:18];
   int tab [0:511];
   int qr[$], qg[$], qb[$], qy[$];

   cmg_color_stage dut (.clock_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .pix_valid_i, .pix_r_i, .pix_g_i, .pix_b_i, .out_valid_o, .out_r_o, .out_g_o, .out_b_o,
      .out_y_o, .cb_coef_from_red_o);

   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
         n_mismatch++;
      end
   endtask

   task automatic report_and_stop();
      if (n_mismatch == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   function automatic int fmask(input int a);
      if (a < 9) return 32'hFFF;
      if (a < 12) return 32'h3FFF;
      if (a == 12) return 32'h77;
      if (a == 13) return 32'hFFFF;
      return (a == 18) ? 32'h1FF : 32'h3FF;
   endfunction

   function automatic int sx(input int v, input int w);
      return (v >= (1 << (w - 1))) ? v - (1 << w) : v;
   endfunction

   function automatic int clip(input int v, input int hi);
      return (v < 0) ? 0 : (v > hi) ? hi : v;
   endfunction

   function automatic int exp_rd(input int a);
      if (a == 20) return ((((m[12] >> 5) & 3) == 2) << 1) | (((m[12] >> 4) & 1) << 2)
                          | (qr.size() > 0);
      if (a == 19) return tab[m[18]];
      return (a < 19) ? m[a] : 0;
   endfunction

   task automatic wr(input int a, input int d);
      @(posedge clock_i);
      wr_i <= 1'b1;
      addr_i <= 5'(a);
      wdata_i <= 16'(d);
      @(posedge clock_i);
      wr_i <= 1'b0;
      if (a < 19) m[a] = d & fmask(a);
      if (a == 19) begin
         tab[m[18]] = d & 32'h3FF;
         m[18] = (m[18] + 1) & 32'h1FF;
      end
   endtask

   task automatic rd_chk(input int a);
      @(posedge clock_i);
      rd_i <= 1'b1;
      addr_i <= 5'(a);
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1;
      chk("rdata", rdata_o, 16'(exp_rd(a)));
   endtask

   // Model of one pixel through matrix, gamma and luma
   task automatic push(input int p[3]);
      int mo[3];
      int s, bits, idx, y, k;
      s = (m[12] >> 5) & 3;
      bits = (s == 0) ? 7 : (s == 3) ? 9 : 8;
      for (k = 0; k < 3; k++) begin
         mo[k] = (sx(m[k], 12) * p[0] + sx(m[3+k], 12) * p[1] + sx(m[6+k], 12) * p[2]) >>> 8;
         mo[k] = clip(mo[k] + sx(m[9+k], 14), 1023);
         idx = mo[k] >> (10 - bits);
         if (((m[12] >> k) & 1) == 0) mo[k] = ((m[12] >> 4) & 1) ? idx << (10 - bits) : tab[idx];
      end
      y = sx(m[14], 10) * mo[0] + sx(m[15], 10) * mo[1] + sx(m[16], 10) * mo[2];
      y = clip(y >>> 8, 1023) >> 2;
      y = clip(((y * (m[13] & 255)) >> 4) + (m[13] >> 8), 255);
      qr.push_back(mo[0]);
      qg.push_back(mo[1]);
      qb.push_back(mo[2]);
      qy.push_back(y);
   endtask

   always @(posedge clock_i) begin
      if (rst_n_i === 1'b1 && out_valid_o === 1'b1) begin
         if (qr.size() == 0) begin
            chk("out_valid", 16'(out_valid_o), 16'h0000);
         end else begin
            chk("out_r", 16'(out_r_o), 16'(qr.pop_front()));
            chk("out_g", 16'(out_g_o), 16'(qg.pop_front()));
            chk("out_b", 16'(out_b_o), 16'(qb.pop_front()));
            chk("out_y", 16'(out_y_o), 16'(qy.pop_front()));
         end
      end
   end

   initial begin
      int k, a, c;
      int p[3];
      {wr_i, rd_i, pix_valid_i, rst_n_i, addr_i, wdata_i} = '0;
      {pix_r_i, pix_g_i, pix_b_i} = '0;
      foreach (m[i]) m[i] = 0;
      m[0] = 256;
      m[4] = 256;
      m[8] = 256;
      m[12] = 39;
      m[13] = 16;
      repeat (16) @(posedge clock_i);
      rst_n_i <= 1'b1;
      for (a = 0; a < 32; a++) if (a != 19) rd_chk(a);
      for (a = 0; a < 19; a++) begin
         wr(a, 32'hFFFF);
         rd_chk(a);
      end
      rd_chk(20);
      wr(18, 0);
      for (k = 0; k < 512; k++) wr(19, $random(seed));
      wr(18, 5);
      rd_chk(19);
      wr(18, 511);
      rd_chk(19);
      for (c = 0; c < 8; c++) begin
         // Odd passes use full-range signed terms so sign extension is exercised
         for (a = 0; a < 18; a++) begin
            if (a != 12) wr(a, $random(seed) & ((a == 13 || (c & 1)) ? 32'hFFFF : 32'h7F));
         end
         // Reserved bits set on purpose: they must not stick
         wr(12, ((c >> 1) << 5) | ((c & 1) << 4) | ((c * 5) & 7) | 32'hFF88);
         rd_chk(12);
         rd_chk(20);
         chk("cb_coef", 16'(cb_coef_from_red_o), 16'(m[17]));
         for (k = 0; k < 12; k++) begin
            @(posedge clock_i);
            foreach (p[i]) p[i] = $random(seed) & 1023;
            pix_valid_i <= 1'b1;
            pix_r_i <= 10'(p[0]);
            pix_g_i <= 10'(p[1]);
            pix_b_i <= 10'(p[2]);
            push(p);
         end
         @(posedge clock_i);
         pix_valid_i <= 1'b0;
         rd_chk(20);
         k = 0;
         while (qr.size() > 0 && k < 20) begin
            @(posedge clock_i);
            k++;
         end
         if (qr.size() > 0) begin
            n_mismatch++;
            report_and_stop();
         end
      end
      report_and_stop();
   end
endmodule
